// file: design/iefr_top.sv
// interrupt control, enable and flag registers behind an AXI4-Lite slave
`timescale 1ns/1ns
// Function
// - global enable bit 7 passes unmasked requests; clear blocks every request
// - peripheral-group enable bit 6 passes or blocks all peripheral requests
// - no peripheral-register source requests unless peripheral-group enable is set
// - control bit 5 gates timer 0 overflow interrupt
// - control bit 4 gates external pin interrupt
// - control bit 3 enables port B change; pin counts only if selected
// - control bit 2 sets on timer 0 rollover, held until software writes 0
// - control bit 1 sets on external pin edge, cleared only by writing 0 or by reset
// - control bit 0 sets on selected port B pin change, held until cleared
// - reset leaves timer 0 counter alone; software initialises it first
// - first enable bit 7 gates timer 1 gate acquisition-complete interrupt
// - first enable bit 6 gates converter completion interrupt
// - first enable bits 5 and 4 gate serial receive and transmit
// - first enable bit 3 gates synchronous serial port interrupt
// - first enable bit 2 gates capture/compare unit 1 interrupt
// - first enable bit 1 gates timer 2 period-match interrupt
// - first enable bit 0 gates timer 1 overflow interrupt
// - second enable bit 7 gates timer 3 gate acquisition-complete interrupt
// - second enable bit 6 gates timer 3 overflow interrupt
// - second enable bits 5 and 4 gate timer B and timer A overflow
// - second enable bits 3..1 read zero, writes ignored
// - second enable bit 0 gates capture/compare unit 2 interrupt
// - flags set on their event regardless of any enable
module iefr_top (
	input  wire logic                       core_clk_i,
	input  wire logic                       resetn_i,
	input  wire logic [iefr_pkg::IEFR_AW-1:0] s_axi_awaddr_i,
	input  wire logic                       s_axi_awvalid_i,
	output logic                            s_axi_awready_o,
	input  wire logic [31:0]                s_axi_wdata_i,
	input  wire logic [3:0]                 s_axi_wstrb_i,
	input  wire logic                       s_axi_wvalid_i,
	output logic                            s_axi_wready_o,
	output logic [1:0]                      s_axi_bresp_o,
	output logic                            s_axi_bvalid_o,
	input  wire logic                       s_axi_bready_i,
	input  wire logic [iefr_pkg::IEFR_AW-1:0] s_axi_araddr_i,
	input  wire logic                       s_axi_arvalid_i,
	output logic                            s_axi_arready_o,
	output logic [31:0]                     s_axi_rdata_o,
	output logic [1:0]                      s_axi_rresp_o,
	output logic                            s_axi_rvalid_o,
	input  wire logic                       s_axi_rready_i,
	input  wire logic                       timer0_rollover_i,
	input  wire logic                       external_irq_pin_i,
	input  wire logic                       ext_rising_edge_i,
	input  wire logic [7:0]                 port_b_pins_i,
	input  wire logic [7:0]                 periph1_flags_i,
	input  wire logic [7:0]                 periph2_flags_i,
	output logic                            irq_o
);
	import iefr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	iefr_state_s s_q;
	iefr_state_s s_d;

	logic        aw_fire;
	logic        w_fire;
	logic        do_write;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic [IEFR_AW-1:0] wr_addr;
	logic [7:0]  pb_change;
	logic        ex_edge;
	logic [7:0]  p1_req;
	logic [7:0]  p2_req;
	logic        core_req;
	logic        periph_req;
	logic [7:0]  rd_byte;
	logic        rd_hit;

	// write channels are taken independently, the response waits for both
	assign s_axi_awready_o = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready_o  = !s_q.w_got && !s_q.bvalid;
	assign s_axi_arready_o = !s_q.rvalid;
	assign s_axi_bvalid_o  = s_q.bvalid;
	assign s_axi_bresp_o   = s_q.bresp;
	assign s_axi_rvalid_o  = s_q.rvalid;
	assign s_axi_rdata_o   = s_q.rdata;
	assign s_axi_rresp_o   = s_q.rresp;
	assign irq_o           = s_q.irq;

	assign aw_fire  = s_axi_awvalid_i && s_axi_awready_o;
	assign w_fire   = s_axi_wvalid_i && s_axi_wready_o;
	assign do_write = (s_q.aw_got || aw_fire) && (s_q.w_got || w_fire);

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	// only pins chosen in the select register count as a change
	assign pb_change = (s_q.pb_sync2 ^ s_q.pb_prev) & s_q.sel;
	// the pin is asynchronous, so its edge is taken after two flops
	assign ex_edge = ext_rising_edge_i ? (s_q.ex_sync[1] && !s_q.ex_prev)
	                                   : (!s_q.ex_sync[1] && s_q.ex_prev);

	// ----------------------------------------------------------------
	// request combination
	// ----------------------------------------------------------------
	// one gate per bit; bit order matches both enable registers
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_gate
			assign p1_req[gi] = periph1_flags_i[gi] & s_q.pe1[gi];
			assign p2_req[gi] = periph2_flags_i[gi] & s_q.pe2[gi];
		end
	endgenerate

	assign core_req = (s_q.ctrl[IEFR_T0F] & s_q.ctrl[IEFR_T0E])
	                | (s_q.ctrl[IEFR_EXF] & s_q.ctrl[IEFR_EXE])
	                | (s_q.ctrl[IEFR_PBF] & s_q.ctrl[IEFR_PBE]);
	assign periph_req = s_q.ctrl[IEFR_PERIPH_GROUP_ENABLE] & (|p1_req | |p2_req);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (s_axi_araddr_i)
			IEFR_OFF_CTRL: rd_byte = s_q.ctrl;
			IEFR_OFF_PE1:  rd_byte = s_q.pe1;
			IEFR_OFF_PE2:  rd_byte = s_q.pe2 & IEFR_PE2_MASK;
			IEFR_OFF_SEL:  rd_byte = s_q.sel;
			default:       rd_hit  = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		wr_en = 1'b0;
		wbyte = 8'h00;
		wr_addr = s_q.aw_got ? s_q.aw_addr : s_axi_awaddr_i;
		s_d.ex_sync  = {s_q.ex_sync[0], external_irq_pin_i};
		s_d.ex_prev  = s_q.ex_sync[1];
		s_d.pb_sync1 = port_b_pins_i;
		s_d.pb_sync2 = s_q.pb_sync1;
		s_d.pb_prev  = s_q.pb_sync2;

		if (aw_fire) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = s_axi_awaddr_i;
		end
		if (w_fire) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = s_axi_wdata_i;
			s_d.w_strb = s_axi_wstrb_i;
		end

		// register write: only byte lane 0 carries data
		if (do_write) begin
			wbyte = s_q.w_got ? s_q.w_data[7:0] : s_axi_wdata_i[7:0];
			wr_en = s_q.w_got ? s_q.w_strb[0] : s_axi_wstrb_i[0];
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = IEFR_RESP_OKAY;
			case (wr_addr)
				IEFR_OFF_CTRL: begin
					if (wr_en) s_d.ctrl = wbyte;
				end
				IEFR_OFF_PE1: begin
					if (wr_en) s_d.pe1 = wbyte;
				end
				IEFR_OFF_PE2: begin
					if (wr_en) s_d.pe2 = wbyte & IEFR_PE2_MASK;
				end
				IEFR_OFF_SEL: begin
					if (wr_en) s_d.sel = wbyte;
				end
				default: s_d.bresp = IEFR_RESP_SLVERR;
			endcase
		end else if (s_q.bvalid && s_axi_bready_i) begin
			s_d.bvalid = 1'b0;
		end

		// flags set after any software write, so a same-cycle event wins
		// timer 0 counter itself lives outside; nothing here resets it
		if (timer0_rollover_i) s_d.ctrl[IEFR_T0F] = 1'b1;
		if (ex_edge)           s_d.ctrl[IEFR_EXF] = 1'b1;
		if (|pb_change)        s_d.ctrl[IEFR_PBF] = 1'b1;

		if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = {24'h000000, rd_byte};
			s_d.rresp  = rd_hit ? IEFR_RESP_OKAY : IEFR_RESP_SLVERR;
		end else if (s_q.rvalid && s_axi_rready_i) begin
			s_d.rvalid = 1'b0;
		end

		s_d.irq = s_q.ctrl[IEFR_GIE] & (core_req | periph_req);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			s_q <= '0;
			s_q.ctrl <= IEFR_CTRL_RST;
			s_q.pe1  <= IEFR_PE1_RST;
			s_q.pe2  <= IEFR_PE2_RST;
			s_q.sel  <= IEFR_SEL_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : iefr_top

// file: design/iefr_pkg.sv
// package: register map, field positions and reset values of the interrupt enable/flag block
package iefr_pkg;
	localparam int IEFR_AW = 4;
	localparam logic [IEFR_AW-1:0] IEFR_OFF_CTRL = 4'h0;
	localparam logic [IEFR_AW-1:0] IEFR_OFF_PE1  = 4'h4;
	localparam logic [IEFR_AW-1:0] IEFR_OFF_PE2  = 4'h8;
	localparam logic [IEFR_AW-1:0] IEFR_OFF_SEL  = 4'hC;
	// control register fields
	localparam int IEFR_GIE  = 7;
	localparam int IEFR_PERIPH_GROUP_ENABLE = 6;
	localparam int IEFR_T0E  = 5;
	localparam int IEFR_EXE  = 4;
	localparam int IEFR_PBE  = 3;
	localparam int IEFR_T0F  = 2;
	localparam int IEFR_EXF  = 1;
	localparam int IEFR_PBF  = 0;
	localparam logic [7:0] IEFR_CTRL_RST = 8'h00;
	localparam logic [7:0] IEFR_PE1_RST  = 8'h00;
	localparam logic [7:0] IEFR_PE2_RST  = 8'h00;
	localparam logic [7:0] IEFR_SEL_RST  = 8'h00;
	// writable bits of the second enable register; bits 3..1 are unimplemented
	localparam logic [7:0] IEFR_PE2_MASK = 8'hF1;
	localparam logic [1:0] IEFR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] IEFR_RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] pe1;
		logic [7:0] pe2;
		logic [7:0] sel;
		logic [7:0] pb_sync1;
		logic [7:0] pb_sync2;
		logic [7:0] pb_prev;
		logic [1:0] ex_sync;
		logic       ex_prev;
		logic       aw_got;
		logic       w_got;
		logic [IEFR_AW-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        irq;
	} iefr_state_s;
endpackage : iefr_pkg

// file: bench/iefr_src.sv
// partner model: timer 0 rollover, external pin, port B pins, peripheral flags
`timescale 1ns/1ns
module iefr_src (
	input  wire logic clk_i,
	output logic       t0_o,
	output logic       ex_o,
	output logic [7:0] pb_o,
	output logic [7:0] p1_o,
	output logic [7:0] p2_o
);
	logic [7:0] cnt = 8'hFF; // count has no reset; its declaration starts it at 8'hFF, so the first rollover pulse needs no load
	initial begin
		{t0_o, ex_o, pb_o, p1_o, p2_o} = 25'h0;
	end
	// 2 = timer rollover pulse, 1 = external pin toggle, 0 = port B pin 0 toggle
	task automatic fire(input int j);
		@(posedge clk_i);
		if (j == 2) cnt <= cnt + 8'h1;
		if (j == 2) t0_o <= (cnt == 8'hFF);
		if (j == 1) ex_o <= ~ex_o;
		if (j == 0) pb_o[0] <= ~pb_o[0];
		@(posedge clk_i);
		t0_o <= 1'h0;
	endtask : fire
	task automatic flags(input logic [15:0] v);
		@(posedge clk_i);
		{p2_o, p1_o} <= v;
	endtask : flags
endmodule : iefr_src

// file: bench/iefr_chk.sv
// checker: bus handshakes and request line at the block ports
`timescale 1ns/1ns
module iefr_chk (
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        s_axi_awvalid_i,
	input  wire logic        s_axi_awready_o,
	input  wire logic        s_axi_wvalid_i,
	input  wire logic        s_axi_wready_o,
	input  wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic        s_axi_arvalid_i,
	input  wire logic        s_axi_arready_o,
	input  wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        irq_o,
	input  wire logic [1:0]  s_axi_bresp_o,
	input  wire logic [31:0] s_axi_rdata_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	a_irq_reset: assert property ($rose(resetn_i) |-> !irq_o ##1 !irq_o)
		else $error("request raised right after reset");
	a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
	a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
	a_b_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write answer repeated");
	a_b_follow: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |=> s_axi_bvalid_o) else $error("write answer late");
	a_r_follow: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_w_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answer pending");
	a_r_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answer pending");
	a_r_byte: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
		else $error("read data above low byte");
	c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
	c_rd: cover property (s_axi_rvalid_o && s_axi_rready_i);
	c_irq: cover property ($rose(irq_o));
endmodule : iefr_chk
bind iefr_top iefr_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_rdata_o(s_axi_rdata_o));

// file: bench/tb_interrupt_enable_flag_regs.sv
// testbench: register access and request gating of the enable/flag block
`timescale 1ns/1ns
module tb_interrupt_enable_flag_regs;
	import iefr_pkg::*;
	logic        clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, edg = 1;
	logic [3:0]  aw = 4'h0, ar = 4'h0, ws = 4'h1;
	logic [31:0] wd = 32'h0, rd;
	logic [1:0]  br, rr;
	logic [7:0]  pb, p1, p2, e, n;
	logic [15:0] m;
	logic        awr, wrdy, bv, arr, rv, t0, ex, irq;
	int          mismatches = 0, tests_run = 0, i, j, c;
	always #25 clk = ~clk;
	iefr_top uut (.core_clk_i(clk), .resetn_i(rstn), .s_axi_awaddr_i(aw),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
		.s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rry), .timer0_rollover_i(t0), .external_irq_pin_i(ex),
		.ext_rising_edge_i(edg), .port_b_pins_i(pb), .periph1_flags_i(p1),
		.periph2_flags_i(p2), .irq_o(irq));
	iefr_src src (.clk_i(clk), .t0_o(t0), .ex_o(ex), .pb_o(pb), .p1_o(p1), .p2_o(p2));
	task automatic chk(input logic [31:0] s, input logic [31:0] x, input string nm);
		tests_run++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic tmo(input int k);
		if (k >= 40) begin
			mismatches++;
			stop_test();
		end
	endtask : tmo
	// ready is held back one cycle on purpose so the answer has to stand
	task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] x);
		int k;
		logic ad, dd;
		{ad, dd, k} = '0;
		@(posedge clk);
		{aw, wd, awv, wv} <= {a, 24'h0, d, 2'h3};
		do begin
			@(posedge clk);
			k++;
			if (awr) ad = 1;
			if (wrdy) dd = 1;
			if (ad) awv <= 1'h0;
			if (dd) wv <= 1'h0;
			if (!bry) bry <= bv;
		end while (!(bv && bry) && k < 40);
		tmo(k);
		chk(br, x, "write response");
		bry <= 1'h0;
	endtask : axw
	task automatic axr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] x);
		int k;
		k = 0;
		@(posedge clk);
		{ar, arv} <= {a, 1'h1};
		do begin
			@(posedge clk);
			k++;
			if (arr) arv <= 1'h0;
			if (!rry) rry <= rv;
		end while (!(rv && rry) && k < 40);
		tmo(k);
		chk(rd, {24'h0, d}, "read data");
		chk(rr, x, "read response");
		rry <= 1'h0;
	endtask : axr
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'h1;
		for (i = 0; i < 16; i += 4) axr(i[3:0], 8'h00, IEFR_RESP_OKAY);
		chk(irq, 1'h0, "irq after reset");
		axw(4'h4, 8'hFF, IEFR_RESP_OKAY);
		axr(4'h4, 8'hFF, IEFR_RESP_OKAY);
		axw(4'h8, 8'hFF, IEFR_RESP_OKAY);
		axr(4'h8, 8'hF1, IEFR_RESP_OKAY);
		ws <= 4'h0;
		axw(4'h4, 8'h00, IEFR_RESP_OKAY);
		ws <= 4'h1;
		axr(4'h4, 8'hFF, IEFR_RESP_OKAY);
		axw(4'h2, 8'hFF, IEFR_RESP_SLVERR);
		axr(4'h2, 8'h00, IEFR_RESP_SLVERR);
		$display("test access done");
		for (i = 0; i < 16; i++) begin
			m = 16'h1 << i;
			src.flags(m);
			axw(4'h4, m[7:0], IEFR_RESP_OKAY);
			axw(4'h8, m[15:8], IEFR_RESP_OKAY);
			for (c = 0; c < 4; c++) begin
				if (c == 3) src.flags(~m);
				axw(4'h0, (c == 1) ? 8'h80 : (c == 2) ? 8'h40 : 8'hC0, IEFR_RESP_OKAY);
				repeat (2) @(posedge clk);
				chk(irq, c == 0 && (i < 9 || i > 11), "irq peripheral");
			end
		end
		src.flags(16'h0);
		$display("test peripheral done");
		axw(4'h0, 8'h00, IEFR_RESP_OKAY);
		axw(4'hC, 8'hFE, IEFR_RESP_OKAY);
		src.fire(0);
		repeat (6) @(posedge clk);
		axr(4'h0, 8'h00, IEFR_RESP_OKAY);
		axw(4'hC, 8'h01, IEFR_RESP_OKAY);
		for (j = 0; j < 3; j++) begin
			src.fire(j);
			repeat (6) @(posedge clk);
			e = 8'h1 << j;
			n = e << 3;
			axr(4'h0, e, IEFR_RESP_OKAY);
			for (c = 0; c < 3; c++) begin
				axw(4'h0, e | ((c == 2) ? n : (c == 1) ? 8'h80 | n : 8'h80), IEFR_RESP_OKAY);
				repeat (2) @(posedge clk);
				chk(irq, c == 1, "irq core");
			end
			axw(4'h0, 8'h80 | n, IEFR_RESP_OKAY);
			axr(4'h0, 8'h80 | n, IEFR_RESP_OKAY);
			chk(irq, 1'h0, "irq cleared");
			axw(4'h0, 8'h00, IEFR_RESP_OKAY);
		end
		edg <= 1'h0;
		src.fire(1);
		repeat (6) @(posedge clk);
		axr(4'h0, 8'h02, IEFR_RESP_OKAY);
		axw(4'h0, 8'h00, IEFR_RESP_OKAY);
		$display("test core sources done");
		stop_test();
	end
endmodule : tb_interrupt_enable_flag_regs
